// File: hdl/sfq_core.sv
// SPI port with mode fault detection, requests and queued transmit data.
`timescale 1ns/1ps
module sfq_core (
    // Clock and reset.
    input  wire logic               core_clk,
    input  wire logic               rst,
    // Configuration bits, software strobes, software data ports and flags.
    input  sfq_pkg::sfq_cfg_t       cfg,
    input  wire logic               sw_status_read,
    input  wire logic               sw_ctrl_write,
    input  wire logic               sw_ctrl_enable,
    input  wire logic               sw_data_read,
    input  wire logic               sw_data_write,
    output logic                    sw_data_ready,
    input  wire logic [7:0]         sw_data_wdata,
    output logic [7:0]              rx_data,
    output sfq_pkg::sfq_flags_t     flags,
    // Requests.
    output logic                    tx_irq,
    output logic                    rx_err_irq,
    // Serial pins.
    input  wire logic               serial_clock_pin_in,
    output logic                    serial_clock_pin_out,
    output logic                    serial_clock_pin_oe,
    input  wire logic               mosi_in,
    output logic                    mosi_out,
    output logic                    mosi_oe,
    input  wire logic               miso_in,
    output logic                    miso_out,
    output logic                    miso_oe,
    input  wire logic               slave_select_n,
    output logic                    spi_owns_pins
);
    sfq_pkg::sfq_state_t state_reg, state_next;
    logic [4:0] edge_reg, edge_next;
    logic [3:0] div_reg, div_next;
    logic [7:0] sh_reg, sh_next, txb_reg, txb_next, rxd_reg, rxd_next;
    logic sck_reg, sck_next, out_reg, out_next, txf_reg, txf_next;
    logic rxf_reg, rxf_next, ovr_reg, ovr_next, mf_reg, mf_next;
    logic en_reg, en_next, mfa_reg, mfa_next;
    logic [1:0] rxa_reg, rxa_next;
    logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_next, prv_reg;
    logic fifo_valid, pop, ss_lo, ss_fall, ss_rise, sck_edge, lead;
    logic mst, slv, mhold, mcond, scond, edge_go, done, din;
    logic [7:0] fifo_data, ld_val;

    ////////////////////////////////////////////////////////////////////////
    // Software bytes wait in the FIFO; the buffer takes one when empty and the port is enabled.
    assign pop = en_reg && !txf_reg;
    sfq_fifo #(.W(sfq_pkg::DATA_W), .D(sfq_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (sw_data_write),
        .in_ready  (sw_data_ready),
        .in_data   (sw_data_wdata),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pins pass three flops; a change is accepted once flops two and
    // three agree, which rejects a single-cycle glitch.
    always_comb begin
        flt_next = flt_reg;
        for (int i = 0; i < 4; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                flt_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_reg <= sfq_pkg::SYNC_RST;
            s2_reg <= sfq_pkg::SYNC_RST;
            s3_reg <= sfq_pkg::SYNC_RST;
            flt_reg <= sfq_pkg::SYNC_RST;
            prv_reg <= sfq_pkg::SYNC_RST;
        end else begin
            s1_reg <= {slave_select_n, miso_in, mosi_in,
                       serial_clock_pin_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
            prv_reg <= flt_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded pin events and fault conditions.
    assign mst = cfg.master_select;
    assign slv = !cfg.master_select;
    assign ss_lo = !flt_reg[sfq_pkg::PIN_SS];
    assign ss_fall = prv_reg[sfq_pkg::PIN_SS] && ss_lo;
    assign ss_rise = !prv_reg[sfq_pkg::PIN_SS] && !ss_lo;
    assign sck_edge = flt_reg[sfq_pkg::PIN_SCK] != prv_reg[sfq_pkg::PIN_SCK];
    assign lead = sck_edge &&
        (flt_reg[sfq_pkg::PIN_SCK] != cfg.clock_polarity_select);
    assign mhold = mst && cfg.fault_detect_enable && ss_lo;
    assign mcond = en_reg && mhold;
    assign scond = en_reg && slv && cfg.fault_detect_enable &&
        (state_reg == sfq_pkg::ST_SXFER) && ss_rise;
    assign din = mst ? flt_reg[sfq_pkg::PIN_MISO]
                     : flt_reg[sfq_pkg::PIN_MOSI];
    assign ld_val = txf_reg ? txb_reg : sh_reg;

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine and flags; clears are applied before sets so that
    // an event in the clearing cycle always survives.
    always_comb begin
        state_next = state_reg;
        edge_next = edge_reg;
        div_next = div_reg;
        sh_next = sh_reg;
        txb_next = txb_reg;
        rxd_next = rxd_reg;
        sck_next = sck_reg;
        out_next = out_reg;
        txf_next = txf_reg;
        rxf_next = rxf_reg;
        ovr_next = ovr_reg;
        mf_next = mf_reg;
        en_next = en_reg;
        mfa_next = mfa_reg;
        rxa_next = rxa_reg;
        edge_go = 1'b0;
        done = 1'b0;
        if (pop && fifo_valid) begin
            txb_next = fifo_data;
            txf_next = 1'b1;
        end
        if (state_reg == sfq_pkg::ST_IDLE) begin
            sck_next = cfg.clock_polarity_select;
            div_next = '0;
            edge_next = '0;
        end
        if (en_reg && mst && state_reg == sfq_pkg::ST_IDLE && txf_reg) begin
            sh_next = txb_reg;
            out_next = txb_reg[7];
            txf_next = 1'b0;
            state_next = sfq_pkg::ST_MXFER;
        end
        if (state_reg == sfq_pkg::ST_MXFER) begin
            div_next = div_reg + 4'h1;
            if (div_reg == sfq_pkg::SCK_HALF_CYC - 4'h1) begin
                div_next = '0;
                sck_next = !sck_reg;
                edge_go = 1'b1;
            end
        end
        if (en_reg && slv) begin
            // phase 0 starts at select fall
            if (!cfg.clock_phase_select && ss_fall) begin
                sh_next = ld_val;
                out_next = ld_val[7];
                txf_next = pop && fifo_valid;
                edge_next = '0;
                state_next = sfq_pkg::ST_SXFER;
            // phase 1 starts at first edge
            end else if (cfg.clock_phase_select && ss_lo && lead &&
                         state_reg == sfq_pkg::ST_IDLE) begin
                sh_next = ld_val;
                out_next = ld_val[7];
                txf_next = pop && fifo_valid;
                edge_next = 5'h1;
                state_next = sfq_pkg::ST_SXFER;
            end else if (state_reg == sfq_pkg::ST_SXFER && ss_lo &&
                         sck_edge) begin
                edge_go = 1'b1;
            end
        end
        if (edge_go) begin
            if (edge_reg[0] == cfg.clock_phase_select) begin
                sh_next = {sh_reg[6:0], din};
            end else begin
                out_next = sh_reg[7];
            end
            edge_next = edge_reg + 5'h1;
            done = (edge_reg + 5'h1) == sfq_pkg::EDGES_PER_BYTE;
        end
        if (done) begin
            state_next = sfq_pkg::ST_IDLE;
        end
        // Status read arms the two-step clears.
        if (sw_status_read) begin
            rxa_next = {ovr_reg, rxf_reg};
            mfa_next = mf_reg;
        end
        if (sw_data_read) begin
            rxf_next = rxf_reg && !rxa_reg[0];
            ovr_next = ovr_reg && !rxa_reg[1];
            rxa_next = '0;
        end
        if (sw_ctrl_write) begin
            en_next = sw_ctrl_enable;
            // clear only with no fault meanwhile
            if (mfa_reg && !mhold && !scond) begin
                mf_next = 1'b0;
            end
            mfa_next = 1'b0;
        end
        if (done) begin
            if (rxf_reg && !(sw_data_read && rxa_reg[0])) begin
                ovr_next = 1'b1;
            end else begin
                rxd_next = sh_next;
                rxf_next = 1'b1;
            end
        end
        // fault gated by fault detect enable
        if (mcond || scond) begin
            mf_next = 1'b1;
            mfa_next = 1'b0;
        end
        // in master mode with fault detect on, low select disarms the clear, even with the port off.
        if (mhold) begin
            mfa_next = 1'b0;
        end
        // master fault shuts the port down
        if (mcond) begin
            en_next = 1'b0;
        end
        // A disabled port aborts and clears; slave faults do not.
        if (!en_reg || mcond) begin
            state_next = sfq_pkg::ST_IDLE;
            edge_next = '0;
            txf_next = 1'b0;
            sh_next = sfq_pkg::SHIFT_RST;
            sck_next = cfg.clock_polarity_select;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= sfq_pkg::ST_IDLE;
            edge_reg <= '0;
            div_reg <= '0;
            sh_reg <= sfq_pkg::SHIFT_RST;
            txb_reg <= '0;
            rxd_reg <= '0;
            sck_reg <= 1'b0;
            out_reg <= 1'b0;
            txf_reg <= 1'b0;
            rxf_reg <= 1'b0;
            ovr_reg <= 1'b0;
            mf_reg <= 1'b0;
            en_reg <= 1'b0;
            mfa_reg <= 1'b0;
            rxa_reg <= '0;
        end else begin
            state_reg <= state_next;
            edge_reg <= edge_next;
            div_reg <= div_next;
            sh_reg <= sh_next;
            txb_reg <= txb_next;
            rxd_reg <= rxd_next;
            sck_reg <= sck_next;
            out_reg <= out_next;
            txf_reg <= txf_next;
            rxf_reg <= rxf_next;
            ovr_reg <= ovr_next;
            mf_reg <= mf_next;
            en_reg <= en_next;
            mfa_reg <= mfa_next;
            rxa_reg <= rxa_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, flags and requests.
    assign spi_owns_pins = en_reg;
    assign serial_clock_pin_out = sck_reg;
    assign serial_clock_pin_oe = en_reg && mst;
    assign mosi_out = out_reg;
    assign mosi_oe = en_reg && mst;
    assign miso_out = out_reg;
    assign miso_oe = en_reg && slv && ss_lo;
    assign rx_data = rxd_reg;
    assign flags = '{spi_enable_bit: en_reg, tx_empty_flag: !txf_reg,
                     rx_full_flag: rxf_reg, overrun_flag: ovr_reg,
                     mode_fault_flag: mf_reg};
    assign tx_irq = !txf_reg && cfg.tx_irq_enable;
    assign rx_err_irq = (rxf_reg && cfg.rx_irq_enable && en_reg) ||
        ((mf_reg || ovr_reg) && cfg.error_irq_enable);

    ////////////////////////////////////////////////////////////////////////
    // Checks on the engine.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence byte_done_s;
        done && !sw_data_read;
    endsequence
    sequence master_start_s;
        state_reg == sfq_pkg::ST_IDLE && state_next == sfq_pkg::ST_MXFER;
    endsequence

    master_fault_a: assert property (mcond |=> mf_reg && !en_reg &&
        !txf_reg && state_reg == sfq_pkg::ST_IDLE) else
        $error("master fault did not shut down");
    slave_fault_a: assert property (scond |=> mf_reg &&
        $past(en_reg) == en_reg) else
        $error("slave fault mishandled");
    fault_gate_a: assert property (!cfg.fault_detect_enable &&
        !mf_reg && !sw_ctrl_write |=> !mf_reg) else
        $error("mode fault set with detection off");
    rx_capture_a: assert property (byte_done_s ##0 !rxf_reg |=>
        rxf_reg && rx_data == $past(sh_next)) else
        $error("received byte not captured");
    overrun_keep_a: assert property (byte_done_s ##0 rxf_reg |=>
        ovr_reg && $stable(rx_data)) else
        $error("overrun corrupted receive data");
    tx_load_a: assert property (master_start_s |=>
        flags.tx_empty_flag && sh_reg == $past(txb_reg)) else
        $error("transmit byte not moved");
    miso_float_a: assert property (!ss_lo |-> !miso_oe) else
        $error("miso driven while deselected");
    queue_go_a: assert property (done && mst && txf_reg && en_reg &&
        !mcond |=> ##1 state_reg == sfq_pkg::ST_MXFER) else
        $error("queued byte did not follow");
endmodule

// File: hdl/sfq_fifo.sv
// Parameterised valid/ready FIFO used to queue transmit bytes.
`timescale 1ns/1ps
module sfq_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]   cnt_reg, cnt_next;
    logic          push, pop;

    // Pointers wrap at the depth, so any depth works, not only powers of two.
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (push) begin
            wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
        end
        cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    assign in_ready = (cnt_reg != (AW + 1)'(D));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
endmodule

// File: hdl/sfq_pkg.sv
// Package holding types and constants of the SPI fault and queue block.
package sfq_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_NS = 50;
    localparam int SCK_HALF_NS = 400;
    localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_NS / CLK_NS);
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    // Bit positions inside the synchroniser vector.
    localparam int PIN_SCK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SS = 3;
    localparam logic [3:0] SYNC_RST = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MXFER = 2'b01,
        ST_SXFER = 2'b10
    } sfq_state_t;

    typedef struct packed {
        logic master_select;
        logic clock_polarity_select;
        logic clock_phase_select;
        logic fault_detect_enable;
        logic tx_irq_enable;
        logic rx_irq_enable;
        logic error_irq_enable;
    } sfq_cfg_t;

    typedef struct packed {
        logic spi_enable_bit;
        logic tx_empty_flag;
        logic rx_full_flag;
        logic overrun_flag;
        logic mode_fault_flag;
    } sfq_flags_t;
endpackage

// File: testbench/sfq_peer.sv
// Far-side SPI device model: slave to a master core, master to a slave core.
`timescale 1ns/1ps
module sfq_peer (
    // Resolved pin levels.
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic miso,
    // Levels this model drives.
    output logic      sck_o,
    output logic      mosi_o,
    output logic      miso_o,
    output logic      ss_n
);
    logic [7:0] rep;
    logic [7:0] got;
    logic [7:0] mrx;

    // Idle clock sits at polarity zero and the select starts released.
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        miso_o = 1'b0;
        ss_n = 1'b1;
        rep = 8'h00;
        got = 8'h00;
        mrx = 8'h00;
    end

    // Slave role: the first reply bit must stand before the first edge.
    task automatic reply(input logic [7:0] b);
        rep = b;
        miso_o = b[7];
    endtask

    always @(posedge sck) begin
        got <= {got[6:0], mosi};
    end

    // Shifting in inverted bits keeps the line moving once the byte is out.
    always @(negedge sck) begin
        rep = {rep[6:0], ~rep[0]};
        miso_o = rep[7];
    end

    // Master role select, driven off the core clock on purpose.
    task automatic sel(input logic lvl);
        ss_n = lvl;
    endtask

    task automatic send(input logic [7:0] b);
        mosi_o = b[7];
        #(sfq_pkg::SCK_HALF_NS);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b1;
            mrx = {mrx[6:0], miso};
            #(sfq_pkg::SCK_HALF_NS);
            sck_o = 1'b0;
            mosi_o = (i > 0) ? b[(i > 0) ? i - 1 : 0] : ~b[0];
            #(sfq_pkg::SCK_HALF_NS);
        end
    endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the SPI fault and queue core.
`timescale 1ns/1ps
module tb_top;
    logic                core_clk;
    logic                rst;
    sfq_pkg::sfq_cfg_t   cfg;
    logic                sw_status_read;
    logic                sw_ctrl_write;
    logic                sw_ctrl_enable;
    logic                sw_data_read;
    logic                sw_data_write;
    logic                sw_data_ready;
    logic [7:0]          sw_data_wdata;
    logic [7:0]          rx_data;
    sfq_pkg::sfq_flags_t flags;
    logic                tx_irq;
    logic                rx_err_irq;
    logic                sck_out;
    logic                sck_oe;
    logic                mosi_out;
    logic                mosi_oe;
    logic                miso_out;
    logic                miso_oe;
    logic                spi_owns_pins;
    logic                sck_w;
    logic                mosi_w;
    logic                miso_w;
    logic                p_sck;
    logic                p_mosi;
    logic                p_miso;
    logic                ss_n;
    int                  mismatches = 0;
    int                  tests_run = 0;
    int                  cyc = 0;
    logic [31:0]         rng = 32'h0000_8231;
    logic [7:0]          b[4];
    logic [7:0]          r[4];

    // Each pin takes the core's level while it drives, else the peer's.
    assign sck_w = sck_oe ? sck_out : p_sck;
    assign mosi_w = mosi_oe ? mosi_out : p_mosi;
    assign miso_w = miso_oe ? miso_out : p_miso;

    // Core under test with every pin triple resolved above.
    sfq_core DUT (
        .core_clk(core_clk), .rst(rst), .cfg(cfg),
        .sw_status_read(sw_status_read), .sw_ctrl_write(sw_ctrl_write),
        .sw_ctrl_enable(sw_ctrl_enable), .sw_data_read(sw_data_read),
        .sw_data_write(sw_data_write), .sw_data_ready(sw_data_ready),
        .sw_data_wdata(sw_data_wdata), .rx_data(rx_data), .flags(flags),
        .tx_irq(tx_irq), .rx_err_irq(rx_err_irq),
        .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe(sck_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_n(ss_n),
        .spi_owns_pins(spi_owns_pins));

    // Far side of the serial link.
    sfq_peer peer (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .sck_o(p_sck),
        .mosi_o(p_mosi), .miso_o(p_miso), .ss_n(ss_n));

    // Core clock.
    always #(sfq_pkg::CLK_NS / 2) core_clk = ~core_clk;

    // A hang is cut short well past the expected run length.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // Repeatable xorshift source.
    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction

    // Expected shared request from the expected flag and enable values.
    function automatic logic exp_err(input logic rie, input logic eie,
                                     input logic en, input logic rf,
                                     input logic ov, input logic mf);
        return (rie & en & rf) | (eie & (ov | mf));
    endfunction

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One-cycle software strobes {status read, ctrl write, data read, write}.
    task automatic sw(input logic [3:0] s, input logic e, input logic [7:0] d);
        @(posedge core_clk);
        {sw_status_read, sw_ctrl_write, sw_data_read, sw_data_write} <= s;
        sw_ctrl_enable <= e;
        sw_data_wdata <= d;
        @(posedge core_clk);
        {sw_status_read, sw_ctrl_write, sw_data_read, sw_data_write} <= 4'h0;
        #1;
    endtask

    // Bounded wait for one flag bit to rise.
    task automatic wait_bit(input int i);
        int n;
        for (n = 0; n < 400 && flags[i] !== 1'b1; n++) begin
            step(1);
        end
        check("flag_wait", 8'(n < 400), 8'h01);
    endtask

    task automatic cfg_set(input logic [6:0] v);
        @(posedge core_clk);
        cfg <= v;
        step(2);
    endtask

    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence: master traffic, master fault, then slave traffic.
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        cfg = 7'h00;
        {sw_status_read, sw_ctrl_write, sw_data_read, sw_data_write} = 4'h0;
        sw_ctrl_enable = 1'b0;
        sw_data_wdata = 8'h00;
        foreach (b[i]) begin
            b[i] = rnd();
            r[i] = rnd();
        end
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        step(4);
        check("flags_rst", 8'(flags), 8'h08);
        check("tx_irq_off", 8'(tx_irq), 8'h00);
        check("ready_rst", 8'(sw_data_ready), 8'h01);
        // Master, no fault detect, all requests enabled.
        cfg_set(7'h47);
        sw(4'h4, 1'b1, 8'h00);
        check("tx_irq_on", 8'(tx_irq), 8'h01);
        check("rx_irq_idle", 8'(rx_err_irq), 8'h00);
        peer.reply(r[0]);
        sw(4'h1, rng[3], b[0]);
        step(2);
        wait_bit(3);
        sw(4'h1, rng[5], b[1]);
        step(4);
        check("tx_empty_q", 8'(flags.tx_empty_flag), 8'h00);
        check("tx_irq_q", 8'(tx_irq), 8'h00);
        wait_bit(2);
        peer.reply(r[1]);
        check("rx_data0", rx_data, r[0]);
        check("mosi0", peer.got, b[0]);
        check("rx_irq", 8'(rx_err_irq), 8'(exp_err(1, 1, 1, 1, 0, 0)));
        step(3);
        check("tx_empty_mv", 8'(flags.tx_empty_flag), 8'h01);
        wait_bit(1);
        check("rx_data_ovr", rx_data, r[0]);
        check("mosi1", peer.got, b[1]);
        cfg_set(7'h40);
        check("err_off", 8'(rx_err_irq), 8'h00);
        cfg_set(7'h41);
        check("err_ovr", 8'(rx_err_irq), 8'(exp_err(0, 1, 1, 1, 1, 0)));
        // Random request enables against the flags left standing here.
        repeat (4) begin
            b[0] = rnd();
            cfg_set({4'h8, b[0][2:0]});
            check("tx_irq_rnd", 8'(tx_irq), 8'(b[0][2]));
            check("err_rnd", 8'(rx_err_irq),
                  8'(exp_err(b[0][1], b[0][0], 1, 1, 1, 0)));
        end
        sw(4'h8, 1'b0, 8'h00);
        sw(4'h2, 1'b0, 8'h00);
        check("rx_clear", 8'(flags[2:1]), 8'h00);
        // Master with fault detect; select driven low mid-byte.
        cfg_set(7'h4f);
        sw(4'h1, 1'b0, rnd());
        step(40);
        peer.sel(1'b0);
        step(8);
        check("mf_master", 8'(flags.mode_fault_flag), 8'h01);
        check("en_cleared", 8'(flags.spi_enable_bit), 8'h00);
        check("tx_empty_mf", 8'(flags.tx_empty_flag), 8'h01);
        check("pins_freed", 8'({spi_owns_pins, sck_oe, mosi_oe}), 8'h00);
        check("err_mf", 8'(rx_err_irq), 8'(exp_err(1, 1, 0, 0, 0, 1)));
        sw(4'h8, 1'b0, 8'h00);
        sw(4'h4, 1'b1, 8'h00);
        check("mf_held", 8'(flags.mode_fault_flag), 8'h01);
        check("cfg_kept", 8'({mosi_oe, miso_oe}), 8'h02);
        peer.sel(1'b1);
        step(6);
        sw(4'h8, 1'b0, 8'h00);
        sw(4'h4, 1'b1, 8'h00);
        step(1);
        check("mf_clear", 8'(flags.mode_fault_flag), 8'h00);
        peer.reply(r[2]);
        sw(4'h1, 1'b0, b[2]);
        wait_bit(2);
        check("mosi_full", peer.got, b[2]);
        check("rx_data2", rx_data, r[2]);
        sw(4'h8, 1'b0, 8'h00);
        sw(4'h2, 1'b0, 8'h00);
        cfg_set(7'h47);
        peer.sel(1'b0);
        step(8);
        check("no_fd", 8'({flags.mode_fault_flag, flags.spi_enable_bit}),
              8'h01);
        peer.sel(1'b1);
        // Slave, phase 0, fault detect on.
        cfg_set(7'h0f);
        sw(4'h1, 1'b0, b[3]);
        peer.sel(1'b0);
        #17;
        peer.send(r[3]);
        step(4);
        check("slv_rx", rx_data, r[3]);
        check("slv_miso", peer.mrx, b[3]);
        peer.sel(1'b1);
        step(8);
        check("slv_end_ok", 8'(flags.mode_fault_flag), 8'h00);
        check("miso_float", 8'(miso_oe), 8'h00);
        sw(4'h8, 1'b0, 8'h00);
        sw(4'h2, 1'b0, 8'h00);
        peer.sel(1'b0);
        #17;
        peer.send(r[0]);
        step(4);
        check("slv_resend", peer.mrx, r[3]);
        check("slv_rx2", rx_data, r[0]);
        peer.sel(1'b1);
        step(8);
        peer.sel(1'b0);
        step(10);
        peer.sel(1'b1);
        step(8);
        check("slv_mf_ph0", 8'(flags.mode_fault_flag), 8'h01);
        check("slv_en_kept", 8'(flags.spi_enable_bit), 8'h01);
        sw(4'h8, 1'b0, 8'h00);
        sw(4'h4, 1'b0, 8'h00);
        sw(4'h4, 1'b1, 8'h00);
        sw(4'h2, 1'b0, 8'h00);
        cfg_set(7'h1f);
        peer.sel(1'b0);
        step(10);
        peer.sel(1'b1);
        step(8);
        check("slv_ph1", 8'(flags[2:0]), 8'h00);
        #17;
        peer.send(rnd());
        step(4);
        check("slv_desel", 8'(flags.rx_full_flag), 8'h00);
        stop_test();
    end
endmodule
